// ===== hw/tti_time_tag_unit.sv
`timescale 1ns/1ps
// Contract
// - 16-bit counter, host readable and writable
// - tick period selectable 2 to 64 us
// - external oscillator may clock the counter
// - host command increments counter one step
// - stamp counter into each message descriptor
// - sync without data clears counter
// - sync with data loads counter
// - rollover sets status flag, requests interrupt
// - optionally clear service request after vector
// - interrupt pulse, sticky level, or read-cleared level
// - mask bit gates every interrupt
// - standard mode: status updates only if masked-in
// - enhanced mode: status updates regardless of mask
// - 16 MHz default, 12 MHz option
// - status has master bit plus mirrored bits
// - command bits reset counter and interrupt
module tti_time_tag_unit #(
  parameter int unsigned NUM_COND = tti_pkg::NUM_COND
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // system-rate enables
  input  wire logic                  sysClkEn,
  input  wire logic                  sel12Mhz,
  // time tag configuration
  input  wire logic [2:0]            tagResSel,
  input  wire logic                  tagExtSel,
  input  wire logic                  extTagTick,
  input  wire logic                  syncClrEn,
  input  wire logic                  syncLoadEn,
  input  wire logic                  rollIntEn,
  // host access to the counter
  input  wire logic                  tagWrite,
  input  wire logic [15:0]           tagWriteData,
  input  wire logic                  tagSwIncr,
  input  wire logic                  tagResetCmd,
  output logic      [15:0]           tagValue,
  // protocol events
  input  wire logic                  syncNoData,
  input  wire logic                  syncWithData,
  input  wire logic [15:0]           syncData,
  input  wire logic                  msgDone,
  output logic      [15:0]           stampWord,
  output logic                       stampValid,
  input  wire logic                  vectorTxDone,
  input  wire logic                  autoSrqClrEn,
  input  wire logic                  srqSet,
  output logic                       srqBit,
  // interrupt handling
  input  wire logic [NUM_COND-1:0]   condEvent,
  input  wire logic [NUM_COND-1:0]   intMask,
  input  wire logic                  enhancedInt,
  input  wire logic [1:0]            intMode,
  input  wire logic                  intResetCmd,
  input  wire logic                  statusRead,
  output logic      [NUM_COND:0]     intStatus,
  output logic                       intOut
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]                tag;
    logic [tti_pkg::PRE_W-1:0]  pre;
    logic [5:0]                 subTicks;
    logic [15:0]                stamp;
    logic                       stampVld;
    logic                       srq;
    logic [NUM_COND-1:0]        status;
    logic                       master;
    logic                       intLine;
  } tti_state_t;

  tti_state_t cur_q;
  tti_state_t nxt_d;

  logic [tti_pkg::PRE_W-1:0]  baseDiv;
  logic [5:0]                 ticksPerLsb;
  logic                       baseTick;
  logic                       intTick;
  logic                       advance;
  logic                       syncClear;
  logic                       syncLoad;
  logic                       tagLoad;
  logic [15:0]                tagNext;
  logic [tti_pkg::PRE_W-1:0]  preNext;
  logic [5:0]                 subNext;
  logic                       rollover;
  logic [NUM_COND-1:0]        events;
  logic [NUM_COND-1:0]        latchEn;
  logic [NUM_COND-1:0]        statusNext;
  logic                       statusClr;
  logic                       maskedHit;
  logic                       masterNext;
  logic                       intNext;
  logic                       srqNext;

  // -------------------------------------------------------------------------
  // tick generation
  // -------------------------------------------------------------------------
  always_comb begin
    if (sel12Mhz) begin
      baseDiv = tti_pkg::PRE_W'(tti_pkg::BASE_DIV12);
    end else begin
      baseDiv = tti_pkg::PRE_W'(tti_pkg::BASE_DIV16);
    end
  end

  // resolutions beyond 64 us are treated as 64 us
  always_comb begin
    case (tagResSel)
      3'h0: begin
        ticksPerLsb = 6'h01;
      end
      3'h1: begin
        ticksPerLsb = 6'h02;
      end
      3'h2: begin
        ticksPerLsb = 6'h04;
      end
      3'h3: begin
        ticksPerLsb = 6'h08;
      end
      3'h4: begin
        ticksPerLsb = 6'h10;
      end
      default: begin
        ticksPerLsb = 6'h20;
      end
    endcase
  end

  assign baseTick = sysClkEn && (cur_q.pre == baseDiv - 6'h01);
  assign intTick  = baseTick && (cur_q.subTicks == ticksPerLsb - 6'h01);
  // the external oscillator is taken as a one-cycle tick already in this domain
  assign advance  = (tagExtSel ? extTagTick : intTick) || tagSwIncr;

  // -------------------------------------------------------------------------
  // counter loads
  // -------------------------------------------------------------------------
  assign syncClear = syncNoData && syncClrEn;
  assign syncLoad  = syncWithData && syncLoadEn;
  assign tagLoad   = tagResetCmd || syncClear || syncLoad || tagWrite;

  // priority: reset command, then sync, then host write, then counting
  always_comb begin
    if (tagResetCmd) begin
      tagNext = tti_pkg::TAG_RESET;
    end else if (syncClear) begin
      tagNext = tti_pkg::TAG_RESET;
    end else if (syncLoad) begin
      tagNext = syncData;
    end else if (tagWrite) begin
      tagNext = tagWriteData;
    end else if (advance) begin
      tagNext = cur_q.tag + 16'h0001;
    end else begin
      tagNext = cur_q.tag;
    end
  end

  // a load in the same cycle overrides the step, so there is no wrap to report
  assign rollover = advance && !tagLoad && (cur_q.tag == tti_pkg::TAG_ALL_ONES);

  // -------------------------------------------------------------------------
  // prescaler
  // -------------------------------------------------------------------------
  // restart on any load so the first step after it is a full period
  always_comb begin
    preNext = cur_q.pre;
    subNext = cur_q.subTicks;
    if (tagLoad) begin
      preNext = '0;
      subNext = '0;
    end else if (sysClkEn) begin
      if (baseTick) begin
        preNext = '0;
        if (intTick) begin
          subNext = '0;
        end else begin
          subNext = cur_q.subTicks + 6'h01;
        end
      end else begin
        preNext = cur_q.pre + 6'h01;
      end
    end
  end

  // -------------------------------------------------------------------------
  // interrupt conditions
  // -------------------------------------------------------------------------
  always_comb begin
    events = condEvent;
    events[tti_pkg::COND_ROLLOVER] = condEvent[tti_pkg::COND_ROLLOVER]
                                   || (rollover && rollIntEn);
  end

  assign latchEn   = enhancedInt ? {NUM_COND{1'b1}} : intMask;
  assign statusClr = intResetCmd
                  || (statusRead && intMode == 2'(tti_pkg::INT_LEVEL_READ));
  assign maskedHit = |(events & intMask);

  // new events win over any clear in the same cycle
  for (genvar i = 0; i < NUM_COND; i++) begin : g_cond
    assign statusNext[i] = (events[i] && latchEn[i])
                        || (cur_q.status[i] && !statusClr);
  end

  always_comb begin
    if (maskedHit) begin
      masterNext = 1'b1;
    end else if (statusClr) begin
      masterNext = 1'b0;
    end else begin
      masterNext = cur_q.master;
    end
  end

  // -------------------------------------------------------------------------
  // interrupt output
  // -------------------------------------------------------------------------
  always_comb begin
    case (intMode)
      2'(tti_pkg::INT_PULSE): begin
        intNext = maskedHit;
      end
      2'(tti_pkg::INT_LEVEL_SW): begin
        intNext = masterNext;
      end
      2'(tti_pkg::INT_LEVEL_READ): begin
        intNext = masterNext;
      end
      default: begin
        intNext = 1'b0;
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // service request bit
  // -------------------------------------------------------------------------
  // the set wins over the automatic clear
  always_comb begin
    if (srqSet) begin
      srqNext = 1'b1;
    end else if (vectorTxDone && autoSrqClrEn) begin
      srqNext = 1'b0;
    end else begin
      srqNext = cur_q.srq;
    end
  end

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    nxt_d          = cur_q;
    nxt_d.tag      = tagNext;
    nxt_d.pre      = preNext;
    nxt_d.subTicks = subNext;
    nxt_d.stampVld = msgDone;
    if (msgDone) begin
      nxt_d.stamp = cur_q.tag;
    end
    nxt_d.srq      = srqNext;
    nxt_d.status   = statusNext;
    nxt_d.master   = masterNext;
    nxt_d.intLine  = intNext;
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign tagValue   = cur_q.tag;
  assign stampWord  = cur_q.stamp;
  assign stampValid = cur_q.stampVld;
  assign srqBit     = cur_q.srq;
  assign intStatus  = {cur_q.master, cur_q.status};
  assign intOut     = cur_q.intLine;

endmodule

// ===== hw/tti_pkg.sv
package tti_pkg;

  // -------------------------------------------------------------------------
  // clocking
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ     = 125000000;
  localparam int unsigned SYS_FREQ16_MHZ  = 16;
  localparam int unsigned SYS_FREQ12_MHZ  = 12;
  localparam int unsigned TICK_BASE_US    = 2;
  // system-clock cycles per base tick (2 us) in each frequency mode
  localparam int unsigned BASE_DIV16      = SYS_FREQ16_MHZ * TICK_BASE_US;
  localparam int unsigned BASE_DIV12      = SYS_FREQ12_MHZ * TICK_BASE_US;

  // -------------------------------------------------------------------------
  // counter and resolution
  // -------------------------------------------------------------------------
  localparam int unsigned TAG_W           = 16;
  localparam logic [15:0] TAG_RESET       = 16'h0000;
  localparam logic [15:0] TAG_ALL_ONES    = 16'hffff;
  localparam int unsigned RES_W           = 3;
  localparam int unsigned RES_COUNT       = 6;
  localparam int unsigned PRE_W           = 6;

  // -------------------------------------------------------------------------
  // interrupt handling
  // -------------------------------------------------------------------------
  localparam int unsigned NUM_COND        = 8;
  localparam int unsigned COND_ROLLOVER   = 0;
  localparam int unsigned COND_SRQ_CLR    = 1;
  localparam logic [7:0]  MASK_RESET      = 8'h00;

  typedef enum logic [1:0] {
    INT_PULSE      = 2'b00,
    INT_LEVEL_SW   = 2'b01,
    INT_LEVEL_READ = 2'b10
  } tti_int_mode_t;

endpackage

// ===== bench/tti_time_tag_unit_props.sv
`timescale 1ns/1ps
module tti_tag_props #(parameter int unsigned NUM_COND = 8) (
  input logic clk, rst, tagWrite, tagResetCmd, syncNoData, syncWithData, syncClrEn,
  input logic syncLoadEn, msgDone, stampValid, enhancedInt, intResetCmd, intOut, rollIntEn,
  input logic [15:0] tagWriteData, syncData, tagValue, stampWord,
  input logic [NUM_COND-1:0] condEvent, intMask,
  input logic [1:0] intMode,
  input logic [NUM_COND:0] intStatus
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_wr; tagWrite && !tagResetCmd && !syncNoData && !syncWithData
    |=> tagValue == $past(tagWriteData); endproperty
  a_wr: assert property (p_wr) else $error("write not loaded");
  property p_rst; tagResetCmd |=> tagValue == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("reset cmd ignored");
  property p_sclr; syncNoData && syncClrEn |=> tagValue == 16'h0000; endproperty
  a_sclr: assert property (p_sclr) else $error("sync clear failed");
  property p_sld; syncWithData && syncLoadEn && !tagResetCmd && !(syncNoData && syncClrEn)
    |=> tagValue == $past(syncData); endproperty
  a_sld: assert property (p_sld) else $error("sync load failed");
  property p_stamp; msgDone |=> stampValid && stampWord == $past(tagValue); endproperty
  a_stamp: assert property (p_stamp) else $error("stamp wrong");
  property p_gate; $past(intMask) == '0 |-> !$rose(intOut); endproperty
  a_gate: assert property (p_gate) else $error("unmasked interrupt");
  property p_pulse; intMode == 2'h0 && intOut && condEvent == '0 && !rollIntEn
    |=> !intOut; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_lvl; intMode == 2'h1 && intOut && !intResetCmd ##1 intMode == 2'h1
    |-> intOut; endproperty
  a_lvl: assert property (p_lvl) else $error("level dropped");
  property p_enh; enhancedInt && condEvent[3] |=> intStatus[3]; endproperty
  a_enh: assert property (p_enh) else $error("status not set");
  c_roll: cover property (tagValue == 16'hffff ##1 tagValue == 16'h0000);
  c_stamp: cover property (msgDone ##1 stampValid);
  c_lvl: cover property (intMode == 2'h1 && intOut);
endmodule
bind tti_time_tag_unit tti_tag_props #(.NUM_COND(NUM_COND)) u_props (.*);

// ===== bench/tti_sys_src.sv
`timescale 1ns/1ps
// emulated system clock: one enable per DIV fast cycles, kept short for run time
module tti_sys_src #(parameter int DIV = 4) (input logic clk, rst, output logic sysClkEn);
  logic [3:0] cnt_q;
  always_ff @(posedge clk or posedge rst)
    if (rst) begin cnt_q <= 4'h0; sysClkEn <= 1'b0; end
    else begin
      cnt_q <= (cnt_q == 4'(DIV-1)) ? 4'h0 : cnt_q + 4'h1;
      sysClkEn <= (cnt_q == 4'(DIV-1));
    end
endmodule

// ===== bench/tti_time_tag_unit_bench.sv
`timescale 1ns/1ps
module tti_time_tag_unit_bench;
  logic clk = 0, rst = 1, sel12Mhz = 0, tagExtSel = 0, extTagTick = 0, syncClrEn = 0;
  logic syncLoadEn = 0, rollIntEn = 0, tagWrite = 0, tagSwIncr = 0, tagResetCmd = 0;
  logic syncNoData = 0, syncWithData = 0, msgDone = 0, vectorTxDone = 0, autoSrqClrEn = 0;
  logic srqSet = 0, enhancedInt = 0, intResetCmd = 0, statusRead = 0;
  logic [2:0] tagResSel = 0;
  logic [15:0] tagWriteData = 0, syncData = 0;
  logic [7:0] condEvent = 0, intMask = 0;
  logic [1:0] intMode = 0;
  wire sysClkEn, stampValid, srqBit, intOut;
  wire [15:0] tagValue, stampWord;
  wire [8:0] intStatus;
  int n_fail = 0, cmp_count = 0;
  tti_sys_src #(.DIV(4)) u_sys (.clk(clk), .rst(rst), .sysClkEn(sysClkEn));
  tti_time_tag_unit DUT (
    .clk(clk), .rst(rst), .sysClkEn(sysClkEn), .sel12Mhz(sel12Mhz),
    .tagResSel(tagResSel), .tagExtSel(tagExtSel), .extTagTick(extTagTick),
    .syncClrEn(syncClrEn), .syncLoadEn(syncLoadEn), .rollIntEn(rollIntEn),
    .tagWrite(tagWrite), .tagWriteData(tagWriteData), .tagSwIncr(tagSwIncr),
    .tagResetCmd(tagResetCmd), .tagValue(tagValue), .syncNoData(syncNoData),
    .syncWithData(syncWithData), .syncData(syncData), .msgDone(msgDone),
    .stampWord(stampWord), .stampValid(stampValid), .vectorTxDone(vectorTxDone),
    .autoSrqClrEn(autoSrqClrEn), .srqSet(srqSet), .srqBit(srqBit),
    .condEvent(condEvent), .intMask(intMask), .enhancedInt(enhancedInt),
    .intMode(intMode), .intResetCmd(intResetCmd), .statusRead(statusRead),
    .intStatus(intStatus), .intOut(intOut));
  always #4 clk = ~clk;
  task nx(input int n); repeat (n) @(negedge clk); endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin n_fail++; $display("BAD %0t got %h want %h", $time, got, exp); end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [15:0] v); tagWriteData = v; tagWrite = 1; nx(1); tagWrite = 0; endtask
  task ev(input logic [7:0] c); condEvent = c; nx(1); condEvent = 0; endtask
  task clr; intResetCmd = 1; nx(1); intResetCmd = 0; endtask
  task rd; statusRead = 1; nx(1); statusRead = 0; endtask
  task t_host;
    tagExtSel = 1; wr(16'h1233); chk(tagValue, 16'h1233);
    tagSwIncr = 1; nx(1); tagSwIncr = 0; chk(tagValue, 16'h1234);
    syncLoadEn = 1; syncData = 16'hbeef; syncWithData = 1; nx(1); syncWithData = 0;
    chk(tagValue, 16'hbeef);
    syncClrEn = 1; syncNoData = 1; nx(1); syncNoData = 0; chk(tagValue, 16'h0000);
    wr(16'h0042); tagResetCmd = 1; nx(1); tagResetCmd = 0; chk(tagValue, 16'h0000);
  endtask
  task t_roll;
    intMode = 2'h1; intMask = 8'h01; rollIntEn = 1; wr(16'hffff);
    extTagTick = 1; nx(1); extTagTick = 0; chk(tagValue, 16'h0000);
    nx(1); chk(intStatus, 9'h101);
    chk(intOut, 1);
    clr; chk(intStatus, 9'h000);
    wr(16'hffff); tagWriteData = 16'h0005; tagWrite = 1; extTagTick = 1; nx(1);
    tagWrite = 0; extTagTick = 0; chk(intStatus, 9'h000);
    rollIntEn = 0;
  endtask
  // settle and edge checks bracket the tick so sysClkEn phase cannot matter
  task tk(input logic s, input int r);
    int n;
    n = (s ? 24 : 32) << r;
    sel12Mhz = s; tagResSel = r[2:0]; tagExtSel = 0; wr(16'h0000);
    nx(n * 4 - 8); chk(tagValue, 16'h0000);
    nx(8); chk(tagValue, 16'h0001);
  endtask
  task t_stamp;
    tagExtSel = 1; wr(16'h00a5); msgDone = 1; nx(1); msgDone = 0;
    chk(stampValid, 1);
    chk(stampWord, 16'h00a5);
    nx(1); chk(stampValid, 0);
  endtask
  task t_int;
    intMask = 8'h08; ev(8'h04); chk(intStatus, 9'h000);
    chk(intOut, 0);
    enhancedInt = 1; ev(8'h04); chk(intStatus, 9'h004);
    clr; intMode = 2'h0; ev(8'h08); chk(intOut, 1);
    nx(1); chk(intOut, 0);
    clr; intMode = 2'h2; ev(8'h08); rd; chk(intOut, 0);
    intMode = 2'h1; ev(8'h08); rd; chk(intOut, 1);
    clr; chk(intOut, 0);
  endtask
  task t_srq;
    srqSet = 1; nx(1); srqSet = 0; chk(srqBit, 1);
    autoSrqClrEn = 1; vectorTxDone = 1; nx(1); vectorTxDone = 0; chk(srqBit, 0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 0;
    chk(intStatus, 9'h000);
    t_host; t_roll;
    for (int r = 0; r < 6; r++) tk(0, r);
    tk(1, 0);
    t_stamp; t_int; t_srq;
    report_and_stop;
  end
  initial begin #500000; n_fail++; report_and_stop; end
endmodule
